/* hw/jrip_top.sv */
// Contract
// - system reset clears core, test reset clears test port, separately
// - device boots on system reset release, test reset may stay low
// - test reset held low keeps test port in reset, core unaffected
// - synchronous test reset: TCK keeps running, device samples on TCK
// - identification variant digit valid only after system reset release
// - other scan instructions work whether system reset is low or high
// - after system reset release, test reset rise latches debug mode pins
// - captured debug mode pins choose boundary scan or emulation; with CTRL_OVR set, the ctrl mode bits choose instead
// - read-only 32-bit identification register, writes ignored
// - top hex digit of identification holds silicon revision, rest fixed
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module jrip_top
  import jrip_pkg::*;
(
  // clock and system reset
  input wire logic mclk,
  input wire logic rst_n,
  // test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic testReset_n,
  output logic tdo,
  output logic tdoOe_n,
  output logic returned_test_clock,
  // debug mode strap pins
  input wire logic [1:0] debug_mode_pins,
  // mode selection result
  output logic emulationMode,
  output logic modeCaptured,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  jrip_core_t core_reg, core_next;
  jrip_test_t test_reg, test_next;
  logic powerOnClr_n;
  logic tckRise;
  logic tckFall;
  logic [1:0] effMode;
  logic [31:0] idValue;
  logic [31:0] statusWord;

  // only the power-up case with both resets low clears the test port
  // asynchronously; system reset alone leaves scan running
  assign powerOnClr_n = rst_n | testReset_n;

  assign tckRise = test_reg.tckS2 & ~test_reg.tckPrev;
  assign tckFall = ~test_reg.tckS2 & test_reg.tckPrev;

  // revision digit is unknown until the core has left reset
  assign idValue = {core_reg.released ? ID_REV : ID_REV_UNKNOWN,
                    ID_FIXED};

  assign effMode = core_reg.ctrl[CTRL_OVR] ?
                   core_reg.ctrl[CTRL_MODE_LSB +: 2] : core_reg.modeCap;

  assign statusWord = {26'h0, test_reg.tap == TAP_TLR, test_reg.trstTck,
                       effMode == DBG_MODE_EMULATION, core_reg.modeValid,
                       core_reg.modeCap};

  function automatic jrip_tap_t tapStep(jrip_tap_t s, logic m);
    unique case (s)
      TAP_TLR: tapStep = m ? TAP_TLR : TAP_RTI;
      TAP_RTI: tapStep = m ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: tapStep = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tapStep = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: tapStep = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tapStep = m ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR: tapStep = m ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tapStep = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tapStep = m ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: tapStep = m ? TAP_TLR : TAP_CAP_IR;
      TAP_CAP_IR: tapStep = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: tapStep = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tapStep = m ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR: tapStep = m ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tapStep = m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tapStep = m ? TAP_SEL_DR : TAP_RTI;
      default: tapStep = TAP_TLR;
    endcase
  endfunction : tapStep

  // test port logic
  always_comb begin
    test_next = test_reg;
    test_next.tckS1 = tck;
    test_next.tckS2 = test_reg.tckS1;
    test_next.tckPrev = test_reg.tckS2;
    test_next.tmsS1 = tms;
    test_next.tmsS2 = test_reg.tmsS1;
    test_next.tdiS1 = tdi;
    test_next.tdiS2 = test_reg.tdiS1;
    test_next.trstS1 = testReset_n;
    test_next.trstS2 = test_reg.trstS1;
    if (tckRise) begin
      test_next.trstTck = test_reg.trstS2;
      if (!test_reg.trstS2) begin
        test_next.tap = TAP_TLR;
        test_next.ir = IR_IDCODE;
      end else begin
        test_next.tap = tapStep(test_reg.tap, test_reg.tmsS2);
        unique case (test_reg.tap)
          TAP_TLR: test_next.ir = IR_IDCODE;
          TAP_CAP_IR: test_next.irShift = IR_CAPTURE;
          TAP_SH_IR: test_next.irShift = {test_reg.tdiS2,
                                          test_reg.irShift[3:1]};
          TAP_UPD_IR: test_next.ir = test_reg.irShift;
          TAP_CAP_DR: begin
            // extest and sample have no cells here and act as bypass
            test_next.drShift = (test_reg.ir == IR_IDCODE) ?
                                idValue : 32'h0000_0000;
          end
          TAP_SH_DR: begin
            if (test_reg.ir == IR_IDCODE) begin
              test_next.drShift = {test_reg.tdiS2, test_reg.drShift[31:1]};
            end else begin
              test_next.drShift[0] = test_reg.tdiS2;
            end
          end
          default: begin
          end
        endcase
      end
    end
    // tdo changes on the falling edge so the controller samples it stable
    if (tckFall) begin
      test_next.tdo = (test_reg.tap == TAP_SH_IR) ?
                      test_reg.irShift[0] : test_reg.drShift[0];
      test_next.tdoOe_n = ~(test_reg.trstTck &&
                            (test_reg.tap == TAP_SH_IR ||
                             test_reg.tap == TAP_SH_DR));
    end
  end

  always_ff @(posedge mclk or negedge powerOnClr_n) begin
    if (!powerOnClr_n) begin
      test_reg <= '{tap: TAP_TLR, ir: IR_IDCODE, tdoOe_n: 1'b1,
                    default: '0};
    end else begin
      test_reg <= test_next;
    end
  end

  // core logic: strap capture and register slave
  always_comb begin
    core_next = core_reg;
    core_next.modeS1 = debug_mode_pins;
    core_next.modeS2 = core_reg.modeS1;
    core_next.trstPrev = test_reg.trstS2;
    core_next.released = 1'b1;
    if (core_reg.released && test_reg.trstS2 && !core_reg.trstPrev) begin
      core_next.modeCap = core_reg.modeS2;
      core_next.modeValid = 1'b1;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      core_next.awPend = 1'b1;
      core_next.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      core_next.wPend = 1'b1;
      core_next.wData = s_axi_wdata;
      core_next.wStrb = s_axi_wstrb;
    end
    if (core_reg.awPend && core_reg.wPend) begin
      core_next.awPend = 1'b0;
      core_next.wPend = 1'b0;
      core_next.bvalid = 1'b1;
      unique case (core_reg.awAddr)
        ID_CODE_ADDR, STATUS_ADDR: core_next.bresp = AXI_OKAY;
        CTRL_ADDR: begin
          core_next.bresp = AXI_OKAY;
          if (core_reg.wStrb[0]) begin
            core_next.ctrl = core_reg.wData[2:0];
          end
        end
        default: core_next.bresp = AXI_SLVERR;
      endcase
    end
    if (core_reg.bvalid && s_axi_bready) begin
      core_next.bvalid = 1'b0;
    end
    if (core_reg.rvalid && s_axi_rready) begin
      core_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      core_next.rvalid = 1'b1;
      core_next.rresp = AXI_OKAY;
      unique case (s_axi_araddr)
        ID_CODE_ADDR: core_next.rdata = idValue;
        STATUS_ADDR: core_next.rdata = statusWord;
        CTRL_ADDR: core_next.rdata = {29'h0, core_reg.ctrl};
        default: begin
          core_next.rdata = 32'h0000_0000;
          core_next.rresp = AXI_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_reg <= '{trstPrev: 1'b1, ctrl: CTRL_RESET, default: '0};
    end else begin
      core_reg <= core_next;
    end
  end

  assign s_axi_awready = ~core_reg.awPend & ~core_reg.bvalid;
  assign s_axi_wready = ~core_reg.wPend & ~core_reg.bvalid;
  assign s_axi_bvalid = core_reg.bvalid;
  assign s_axi_bresp = core_reg.bresp;
  assign s_axi_arready = ~core_reg.rvalid;
  assign s_axi_rvalid = core_reg.rvalid;
  assign s_axi_rresp = core_reg.rresp;
  assign s_axi_rdata = core_reg.rdata;

  assign tdo = test_reg.tdo;
  assign tdoOe_n = test_reg.tdoOe_n;
  assign returned_test_clock = test_reg.tckPrev;
  assign emulationMode = (effMode == DBG_MODE_EMULATION);
  assign modeCaptured = core_reg.modeValid;

  // checks on the test port
  tap_held_reset_a: assert property (@(posedge mclk)
    disable iff (!powerOnClr_n)
    tckRise && !test_reg.trstS2 |=> test_reg.tap == TAP_TLR ##1
    (test_reg.tap == TAP_TLR || tckRise))
    else $error("tap left reset while test reset low");

  trst_on_tck_a: assert property (@(posedge mclk)
    disable iff (!powerOnClr_n)
    !tckRise |=> test_reg.trstTck == $past(test_reg.trstTck))
    else $error("test reset sampled away from tck edge");

  scan_in_reset_a: assert property (@(posedge mclk)
    disable iff (!powerOnClr_n)
    tckRise && test_reg.trstS2 && test_reg.tap == TAP_TLR &&
    !test_reg.tmsS2 |=> test_reg.tap == TAP_RTI)
    else $error("tap did not leave reset state");

  ir_update_a: assert property (@(posedge mclk)
    disable iff (!powerOnClr_n)
    tckRise && test_reg.trstS2 && test_reg.tap == TAP_UPD_IR
    |=> test_reg.ir == $past(test_reg.irShift))
    else $error("instruction not updated");

  tdo_quiet_a: assert property (@(posedge mclk)
    disable iff (!powerOnClr_n)
    !test_reg.trstTck && tckFall |=> test_reg.tdoOe_n)
    else $error("tdo driven while port in reset");

  ir_capture_a: assert property (@(posedge mclk)
    disable iff (!powerOnClr_n)
    tckRise && test_reg.trstS2 && test_reg.tap == TAP_CAP_IR
    |=> test_reg.irShift == IR_CAPTURE)
    else $error("instruction capture pattern wrong");

  id_capture_a: assert property (@(posedge mclk)
    disable iff (!powerOnClr_n)
    tckRise && test_reg.trstS2 && test_reg.tap == TAP_CAP_DR &&
    test_reg.ir == IR_IDCODE |=> test_reg.drShift[27:0] == ID_FIXED)
    else $error("fixed identification digits wrong");

  bypass_capture_a: assert property (@(posedge mclk)
    disable iff (!powerOnClr_n)
    tckRise && test_reg.trstS2 && test_reg.tap == TAP_CAP_DR &&
    test_reg.ir != IR_IDCODE |=> !test_reg.drShift[0])
    else $error("bypass cell did not capture zero");

  tdo_drive_a: assert property (@(posedge mclk)
    disable iff (!powerOnClr_n)
    tckFall && test_reg.trstTck && test_reg.tap == TAP_SH_DR
    |=> !test_reg.tdoOe_n)
    else $error("tdo not driven during data shift");

  // checks on the core
  boot_release_a: assert property (@(posedge mclk)
    disable iff (!rst_n) $past(rst_n) |-> core_reg.released)
    else $error("core not released after reset");

  variant_gate_a: assert property (@(posedge mclk)
    disable iff (!powerOnClr_n)
    !core_reg.released |-> idValue[31:28] == ID_REV_UNKNOWN)
    else $error("revision shown before release");

  mode_capture_a: assert property (@(posedge mclk)
    disable iff (!rst_n)
    core_reg.released && test_reg.trstS2 && !core_reg.trstPrev
    |=> core_reg.modeValid && core_reg.modeCap == $past(core_reg.modeS2))
    else $error("mode pins not captured");

  mode_cause_a: assert property (@(posedge mclk)
    disable iff (!rst_n)
    $rose(core_reg.modeValid) |-> $past(test_reg.trstS2 && !core_reg.trstPrev))
    else $error("mode captured without test reset edge");

  mode_select_a: assert property (@(posedge mclk)
    disable iff (!rst_n)
    !core_reg.ctrl[CTRL_OVR] |-> emulationMode ==
    (core_reg.modeCap == DBG_MODE_EMULATION))
    else $error("wrong operating mode");

  id_read_a: assert property (@(posedge mclk)
    disable iff (!rst_n)
    core_reg.released && s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == ID_CODE_ADDR
    |=> s_axi_rvalid && s_axi_rdata == {ID_REV, ID_FIXED})
    else $error("identification read wrong");

  id_write_a: assert property (@(posedge mclk)
    disable iff (!rst_n)
    core_reg.awPend && core_reg.wPend && core_reg.awAddr == ID_CODE_ADDR
    |=> $stable(core_reg.ctrl) && s_axi_bvalid && s_axi_bresp == AXI_OKAY)
    else $error("identification write had an effect");

  id_read_c: cover property (@(posedge mclk) disable iff (!rst_n)
    s_axi_rvalid && s_axi_rready && s_axi_rdata == {ID_REV, ID_FIXED});
  mode_cap_c: cover property (@(posedge mclk) disable iff (!rst_n)
    $rose(core_reg.modeValid));
  id_scan_c: cover property (@(posedge mclk) disable iff (!powerOnClr_n)
    test_reg.tap == TAP_SH_DR && test_reg.ir == IR_IDCODE && tckFall);
  ir_scan_c: cover property (@(posedge mclk) disable iff (!powerOnClr_n)
    test_reg.tap == TAP_UPD_IR && tckRise);

endmodule : jrip_top
`default_nettype wire

/* hw/jrip_pkg.sv */
package jrip_pkg;

  // register map
  localparam logic [31:0] ID_CODE_ADDR = 32'h01C4_0028;
  localparam logic [31:0] STATUS_ADDR = 32'h01C4_002C;
  localparam logic [31:0] CTRL_ADDR = 32'h01C4_0030;

  // identification value: arbitrary neutral codes, not a real part
  localparam logic [3:0] ID_REV = 4'h1;
  localparam logic [27:0] ID_FIXED = 28'h05AC0F1;
  localparam logic [3:0] ID_REV_UNKNOWN = 4'h0;

  // instruction register
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_SAMPLE = 4'h2;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // debug mode pin code that selects emulation
  localparam logic [1:0] DBG_MODE_EMULATION = 2'h3;

  // status and control fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_VALID = 2;
  localparam int ST_EMULATION = 3;
  localparam int ST_TAP_LIVE = 4;
  localparam int ST_TAP_TLR = 5;
  localparam int CTRL_OVR = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [15:0] {
    TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008, TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020,
    TAP_PA_DR = 16'h0040, TAP_EX2_DR = 16'h0080, TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PA_IR = 16'h2000, TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } jrip_tap_t;

  typedef struct packed {
    logic [1:0] modeS1;
    logic [1:0] modeS2;
    logic trstPrev;
    logic released;
    logic [1:0] modeCap;
    logic modeValid;
    logic [2:0] ctrl;
    logic awPend;
    logic [31:0] awAddr;
    logic wPend;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } jrip_core_t;

  typedef struct packed {
    logic tckS1;
    logic tckS2;
    logic tckPrev;
    logic tmsS1;
    logic tmsS2;
    logic tdiS1;
    logic tdiS2;
    logic trstS1;
    logic trstS2;
    logic trstTck;
    jrip_tap_t tap;
    logic [3:0] ir;
    logic [3:0] irShift;
    logic [31:0] drShift;
    logic tdo;
    logic tdoOe_n;
  } jrip_test_t;

endpackage : jrip_pkg

/* testbench/jrip_jtag_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module jrip_jtag_ctl (
  // test port pins
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic testReset_n,
  input wire logic tdo,
  input wire logic tdoOe_n
);
  logic dummy;
  // the test clock stands still low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    testReset_n = 1'b0;
  end
  // tdo is read late in the high phase; only trusted while driven
  task cyc(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    #200 tck <= 1'b1;
    #190 q = (tdoOe_n === 1'b0) ? tdo : 1'bx;
    #10 tck <= 1'b0;
  endtask : cyc
  task walk(input logic [7:0] pat, input int n);
    for (int i = 0; i < n; i++) cyc(pat[i], 1'b0, dummy);
  endtask : walk
  task pulse_reset();
    testReset_n <= 1'b0;
    walk(8'h07, 3);
    testReset_n <= 1'b1;
    walk(8'h00, 1);
  endtask : pulse_reset
  task scan_ir(input logic [3:0] c, output logic [3:0] cap);
    walk(8'h03, 4);
    for (int i = 0; i < 4; i++) cyc(i == 3, c[i], cap[i]);
    walk(8'h01, 2);
  endtask : scan_ir
  task scan_dr(input logic d, output logic [31:0] q);
    walk(8'h01, 3);
    for (int i = 0; i < 32; i++) cyc(i == 31, d, q[i]);
    walk(8'h01, 2);
  endtask : scan_dr
endmodule : jrip_jtag_ctl
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module testbench;
  import jrip_pkg::*;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wr;
    logic [1:0] bresp;
    logic [31:0] rd;
    logic [1:0] rresp;
  } jrip_row_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] debug_mode_pins = 2'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, retClk, emulSel, capd;
  logic tck, tms, tdi, trst_n, tdo, tdoOe_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int errors = 0, comparisons = 0;
  jrip_row_t rows [4] = '{
    '{ID_CODE_ADDR, 32'hFFFF_FFFF, AXI_OKAY, {ID_REV, ID_FIXED}, AXI_OKAY},
    '{CTRL_ADDR, 32'h0000_0006, AXI_OKAY, 32'h0000_0006, AXI_OKAY},
    '{32'h01C4_0034, 32'hFFFF_FFFF, AXI_SLVERR, 32'h0, AXI_SLVERR},
    '{CTRL_ADDR, 32'h0, AXI_OKAY, 32'h0, AXI_OKAY}};
  logic [3:0] bypassCodes [3] = '{IR_EXTEST, IR_SAMPLE, IR_BYPASS};

  always #25 mclk = ~mclk;

  jrip_top dut_u (.mclk(mclk), .rst_n(rst_n), .tck(tck), .tms(tms),
    .tdi(tdi), .testReset_n(trst_n), .tdo(tdo), .tdoOe_n(tdoOe_n),
    .returned_test_clock(retClk), .debug_mode_pins(debug_mode_pins),
    .emulationMode(emulSel), .modeCaptured(capd), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  jrip_jtag_ctl ctl_u (.tck(tck), .tms(tms), .tdi(tdi),
    .testReset_n(trst_n), .tdo(tdo), .tdoOe_n(tdoOe_n));

  task test_done();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task axi_wr(input logic [31:0] a, input logic [31:0] d,
              output logic [1:0] r);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [31:0] a, output logic [31:0] d,
              output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // identification scan, then the extest, sample and bypass one-bit paths with ones fed in
  task id_scans(input logic [31:0] idv);
    logic [3:0] c;
    logic [31:0] q;
    ctl_u.scan_ir(IR_IDCODE, c);
    `CHK(c, IR_CAPTURE)
    ctl_u.scan_dr(1'b0, q);
    `CHK(q, idv)
    foreach (bypassCodes[i]) begin
      ctl_u.scan_ir(bypassCodes[i], c);
      ctl_u.scan_dr(1'b1, q);
      `CHK(q, 32'hFFFF_FFFE)
    end
  endtask : id_scans

  initial begin
    logic [1:0] r;
    logic [31:0] d;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    `CHK(capd, 1'b0)
    axi_rd(CTRL_ADDR, d, r);
    `CHK(d, 32'h0)
    foreach (rows[i]) begin
      axi_wr(rows[i].addr, rows[i].wr, r);
      `CHK(r, rows[i].bresp)
      axi_rd(rows[i].addr, d, r);
      `CHK({r, d}, {rows[i].rresp, rows[i].rd})
    end
    // clocking toward a shift state must not wake the port in reset
    ctl_u.walk(8'h02, 4);
    `CHK(tdoOe_n, 1'b1)
    `CHK(retClk, 1'b1)
    axi_rd(STATUS_ADDR, d, r);
    `CHK(d[ST_TAP_TLR], 1'b1)
    // retimed test clock trails the pin by the two synchroniser stages plus the edge-detect register
    repeat (2) @(posedge mclk);
    `CHK(retClk, 1'b0)
    debug_mode_pins <= DBG_MODE_EMULATION;
    ctl_u.pulse_reset();
    `CHK({capd, emulSel}, 2'b11)
    axi_rd(STATUS_ADDR, d, r);
    `CHK(d[3:0], 4'hF)
    id_scans({ID_REV, ID_FIXED});
    @(posedge mclk);
    rst_n <= 1'b0;
    debug_mode_pins <= 2'h1;
    @(posedge mclk);
    `CHK(capd, 1'b0)
    id_scans({ID_REV_UNKNOWN, ID_FIXED});
    @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    `CHK(capd, 1'b0)
    ctl_u.pulse_reset();
    `CHK({capd, emulSel}, 2'b10)
    id_scans({ID_REV, ID_FIXED});
    test_done();
  end

  initial begin
    #2000000;
    errors++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
